// ---- fp_operate_dispatch.sv ----
// floating-point operate dispatch, register file and result selection
`timescale 1ns/10ps

// What this block does
// - Negate returns the single source word with only bit 31 inverted.
// - Absolute value returns the single source word with bit 31 cleared.
// - Double to single conversion reads an even/odd register pair and returns all three results.
// - Extended conversions read three registers of an aligned group and return all results.
// - Square root takes one operand of any precision and returns root, exceptions and completion.
// - Add sums the first and second operands of the chosen precision with exceptions and completion.
// - Subtract yields first minus second operand with exceptions and completion.
// - Multiply yields the product in any precision with exceptions and completion.
// - Divide yields first over second operand with exceptions and completion.
// - Ordinary compare writes no register and returns a two-bit code, exceptions and completion.
// - The alternate compare has its own opcodes and routine per precision with the same returns.
// - The register file holds 32 words of 32 bits loaded and stored only through memory.
// - Exceptions are five bits and the condition code uses the status register encoding.
module fp_operate_dispatch
    import fp_dispatch_pkg::*;
(
    // clock, reset, enable
    input  wire logic              clk_i,
    input  wire logic              arst_n_i,
    input  wire logic              en_i,
    // instruction issue
    input  wire issue_s            issue_i,
    output logic                   busy_o,
    // memory load and store path
    input  wire mem_s              mem_i,
    output logic [WORD_W-1:0]      mem_rd_data_o,
    // arithmetic unit
    output au_req_s                au_o,
    input  wire au_resp_s          au_i,
    // completion to status register
    output status_s                status_o
);

    typedef struct packed {
        state_e            state;
        regfile_t          regs;
        opcode_s           op;
        logic [IDX_W-1:0]  dest;
        logic [OPND_W-1:0] res;
        logic [EXC_W-1:0]  texc;
        logic [FCC_W-1:0]  tfcc;
        logic              c;
        logic              illegal;
        au_req_s           au;
        status_s           stat;
        logic [WORD_W-1:0] mem_rd;
        logic              busy;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic   rst_meta_reg;
    logic   rst_n_reg;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    function automatic logic op_legal(opcode_s op);
        logic ok_src;
        logic ok_dst;
        ok_src = (op.src_prec != 2'h3);
        ok_dst = (op.dst_prec != 2'h3);
        unique case (op.kind)
            KIND_MOVE, KIND_NEG, KIND_ABS: begin
                op_legal = (op.src_prec == PREC_SGL) && (op.dst_prec == PREC_SGL);
            end
            KIND_CVT: begin
                op_legal = ok_src && ok_dst && (op.src_prec != op.dst_prec);
            end
            KIND_SQRT, KIND_ADD, KIND_SUB, KIND_MUL, KIND_DIV, KIND_CMP, KIND_CMPE: begin
                op_legal = ok_src && (op.dst_prec == op.src_prec);
            end
            default: begin
                op_legal = 1'b0;
            end
        endcase
    endfunction : op_legal

    function automatic logic is_local(opcode_s op);
        is_local = (op.kind == KIND_MOVE) || (op.kind == KIND_NEG) || (op.kind == KIND_ABS);
    endfunction : is_local

    function automatic logic is_compare(opcode_s op);
        is_compare = (op.kind == KIND_CMP) || (op.kind == KIND_CMPE);
    endfunction : is_compare

    // operand words, even register in the upper word
    function automatic logic [OPND_W-1:0] gather(regfile_t rf, logic [IDX_W-1:0] idx,
                                                 logic [1:0] prec);
        logic [IDX_W-1:0] b;
        b = idx;
        gather = '0;
        if (prec == PREC_EXT) begin
            b = {idx[4:2], 2'b00};
            gather = {rf[b], rf[b | IDX_ONE], rf[b | IDX_TWO]};
        end else if (prec == PREC_DBL) begin
            b = {idx[4:1], 1'b0};
            gather = {32'h0000_0000, rf[b], rf[b | IDX_ONE]};
        end else begin
            gather = {64'h0000_0000_0000_0000, rf[idx]};
        end
    endfunction : gather

    function automatic regfile_t scatter(regfile_t rf, logic [IDX_W-1:0] idx,
                                         logic [1:0] prec, logic [OPND_W-1:0] d);
        logic [IDX_W-1:0] b;
        b = idx;
        scatter = rf;
        if (prec == PREC_EXT) begin
            b = {idx[4:2], 2'b00};
            scatter[b]           = d[95:64];
            scatter[b | IDX_ONE] = d[63:32];
            scatter[b | IDX_TWO] = d[31:0];
        end else if (prec == PREC_DBL) begin
            b = {idx[4:1], 1'b0};
            scatter[b]           = d[63:32];
            scatter[b | IDX_ONE] = d[31:0];
        end else begin
            scatter[idx] = d[31:0];
        end
    endfunction : scatter

    logic [OPND_W-1:0] opa_w;
    logic [OPND_W-1:0] opb_w;
    logic              take_w;
    logic              legal_w;

    assign opa_w   = gather(st_reg.regs, issue_i.first_source_index, issue_i.op.src_prec);
    assign opb_w   = gather(st_reg.regs, issue_i.second_source_index, issue_i.op.src_prec);
    assign take_w  = issue_i.valid && (st_reg.state == ST_IDLE);
    assign legal_w = op_legal(issue_i.op);

    always_comb begin
        st_next           = st_reg;
        st_next.au.req    = 1'b0;
        st_next.stat.done = 1'b0;
        unique case (st_reg.state)
            ST_IDLE: begin
                if (take_w) begin
                    st_next.op      = issue_i.op;
                    st_next.dest    = issue_i.dest_index;
                    st_next.tfcc    = FCC_EQ;
                    st_next.illegal = !legal_w;
                    st_next.state   = ST_WB;
                    if (!legal_w) begin
                        st_next.texc = EXC_NONE;
                        st_next.c    = 1'b0;
                    end else if (is_local(issue_i.op)) begin
                        st_next.texc = EXC_NONE;
                        st_next.c    = 1'b1;
                        unique case (issue_i.op.kind)
                            KIND_NEG: st_next.res = {64'h0, opb_w[31:0] ^ SIGN_MASK};
                            KIND_ABS: st_next.res = {64'h0, opb_w[31:0] & MAG_MASK};
                            default:  st_next.res = {64'h0, opb_w[31:0]};
                        endcase
                    end else begin
                        // unary ops take the second source, others both
                        st_next.au.req = 1'b1;
                        st_next.au.op  = issue_i.op;
                        st_next.au.opa = opa_w;
                        st_next.au.opb = opb_w;
                        st_next.state  = ST_WAIT;
                    end
                end
            end
            ST_WAIT: begin
                // root, sum, difference, product, quotient, converts
                if (au_i.done) begin
                    st_next.res   = au_i.result;
                    st_next.texc  = au_i.texc;
                    st_next.tfcc  = au_i.tfcc;
                    st_next.c     = au_i.c;
                    st_next.state = ST_WB;
                end
            end
            ST_WB: begin
                st_next.stat.done      = 1'b1;
                st_next.stat.illegal   = st_reg.illegal;
                st_next.stat.c         = st_reg.c;
                st_next.stat.texc      = st_reg.texc;
                st_next.stat.fcc_valid = is_compare(st_reg.op) && !st_reg.illegal;
                st_next.stat.fcc       = st_reg.tfcc;
                if (!is_compare(st_reg.op) && !st_reg.illegal && st_reg.c) begin
                    st_next.regs = scatter(st_reg.regs, st_reg.dest, st_reg.op.dst_prec,
                                           st_reg.res);
                end
                st_next.state = ST_IDLE;
            end
            default: begin
                st_next.state = ST_IDLE;
            end
        endcase
        // memory is the only other path
        if (mem_i.wr) begin
            st_next.regs[mem_i.wr_index] = mem_i.wr_data;
        end
        st_next.mem_rd = st_next.regs[mem_i.rd_index];
        st_next.busy   = (st_next.state != ST_IDLE);
    end

    always_ff @(posedge clk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            st_reg       <= '0;
            st_reg.state <= ST_IDLE;
        end else if (en_i) begin
            st_reg <= st_next;
        end
    end

    assign busy_o        = st_reg.busy;
    assign mem_rd_data_o = st_reg.mem_rd;
    assign au_o          = st_reg.au;
    assign status_o      = st_reg.stat;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_reg);

    AST_NEGATE: assert property (
        en_i && take_w && legal_w && issue_i.op.kind == KIND_NEG
        |=> st_reg.res[31:0] == ($past(st_reg.regs[issue_i.second_source_index]) ^ SIGN_MASK))
        else $error("negate result wrong");
    AST_ABSOLUTE: assert property (
        en_i && take_w && legal_w && issue_i.op.kind == KIND_ABS
        |=> st_reg.res[31:0] == ($past(st_reg.regs[issue_i.second_source_index]) & MAG_MASK))
        else $error("absolute result wrong");
    AST_LOCAL_CLEAN: assert property (
        status_o.done && is_local(st_reg.op) && !status_o.illegal
        |-> status_o.texc == EXC_NONE && status_o.c)
        else $error("local op reported exception");
    AST_CMP_NOWRITE: assert property (
        en_i && st_reg.state == ST_WB && is_compare(st_reg.op) && !mem_i.wr
        |=> st_reg.regs == $past(st_reg.regs))
        else $error("compare wrote a register");
    AST_AU_ISSUE: assert property (
        en_i && take_w && legal_w && !is_local(issue_i.op)
        |=> au_o.req && au_o.op == $past(issue_i.op))
        else $error("arithmetic request missing");
    AST_EXT_TRIPLE: assert property (
        $rose(au_o.req) && au_o.op.src_prec == PREC_EXT
        |-> au_o.opb[31:0] == $past(st_reg.regs[{issue_i.second_source_index[4:2], 2'b10}]))
        else $error("extended operand misaligned");
    AST_DBL_PAIR: assert property (
        $rose(au_o.req) && au_o.op.src_prec == PREC_DBL
        |-> au_o.opb[95:64] == 32'h0000_0000
            && au_o.opb[63:32] == $past(st_reg.regs[{issue_i.second_source_index[4:1], 1'b0}]))
        else $error("double operand not a pair");
    AST_DONE_PULSE: assert property (
        status_o.done && en_i |=> !status_o.done)
        else $error("done held too long");
    AST_FCC_CMP_ONLY: assert property (
        status_o.fcc_valid && status_o.done |-> is_compare(st_reg.op) && !status_o.illegal)
        else $error("code from non-compare");
    AST_WB_DONE: assert property (
        en_i && st_reg.state == ST_WB |=> status_o.done && !busy_o)
        else $error("writeback did not complete");

    COV_NEG: cover property (status_o.done && st_reg.op.kind == KIND_NEG);
    COV_CMP: cover property (status_o.done && status_o.fcc_valid);
    COV_EXT_ADD: cover property (au_o.req && au_o.op.kind == KIND_ADD
                                 && au_o.op.src_prec == PREC_EXT);
    COV_CVT_DS: cover property (au_o.req && au_o.op.kind == KIND_CVT
                                && au_o.op.src_prec == PREC_DBL
                                && au_o.op.dst_prec == PREC_SGL);
    COV_ILLEGAL: cover property (status_o.done && status_o.illegal);

endmodule : fp_operate_dispatch

// ---- fp_dispatch_pkg.sv ----
// shared types and constants for the floating-point operate dispatcher
package fp_dispatch_pkg;

    localparam int REG_COUNT = 32;
    localparam int WORD_W    = 32;
    localparam int IDX_W     = 5;
    localparam int OPND_W    = 96;
    localparam int EXC_W     = 5;
    localparam int FCC_W     = 2;

    typedef logic [REG_COUNT-1:0][WORD_W-1:0] regfile_t;

    // precision codes; 2'h3 is illegal
    localparam logic [1:0] PREC_SGL = 2'h0;
    localparam logic [1:0] PREC_DBL = 2'h1;
    localparam logic [1:0] PREC_EXT = 2'h2;

    // register alignment offsets inside a pair or triple
    localparam logic [IDX_W-1:0] IDX_ONE = 5'h01;
    localparam logic [IDX_W-1:0] IDX_TWO = 5'h02;

    localparam logic [WORD_W-1:0] SIGN_MASK = 32'h8000_0000;
    localparam logic [WORD_W-1:0] MAG_MASK  = 32'h7fff_ffff;

    // condition-code encoding, same as the status register field
    localparam logic [FCC_W-1:0] FCC_EQ = 2'h0;
    localparam logic [FCC_W-1:0] FCC_LT = 2'h1;
    localparam logic [FCC_W-1:0] FCC_GT = 2'h2;
    localparam logic [FCC_W-1:0] FCC_UN = 2'h3;

    localparam logic [EXC_W-1:0] EXC_NONE = 5'h00;

    typedef enum logic [3:0] {
        KIND_MOVE = 4'h0,
        KIND_NEG  = 4'h1,
        KIND_ABS  = 4'h2,
        KIND_CVT  = 4'h3,
        KIND_SQRT = 4'h4,
        KIND_ADD  = 4'h5,
        KIND_SUB  = 4'h6,
        KIND_MUL  = 4'h7,
        KIND_DIV  = 4'h8,
        KIND_CMP  = 4'h9,
        KIND_CMPE = 4'ha
    } kind_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_WB   = 2'b11
    } state_e;

    typedef struct packed {
        logic [3:0] kind;
        logic [1:0] src_prec;
        logic [1:0] dst_prec;
    } opcode_s;

    typedef struct packed {
        logic             valid;
        opcode_s          op;
        logic [IDX_W-1:0] first_source_index;
        logic [IDX_W-1:0] second_source_index;
        logic [IDX_W-1:0] dest_index;
    } issue_s;

    typedef struct packed {
        logic              req;
        opcode_s           op;
        logic [OPND_W-1:0] opa;
        logic [OPND_W-1:0] opb;
    } au_req_s;

    typedef struct packed {
        logic              done;
        logic [OPND_W-1:0] result;
        logic [EXC_W-1:0]  texc;
        logic [FCC_W-1:0]  tfcc;
        logic              c;
    } au_resp_s;

    typedef struct packed {
        logic             done;
        logic             illegal;
        logic             c;
        logic [EXC_W-1:0] texc;
        logic             fcc_valid;
        logic [FCC_W-1:0] fcc;
    } status_s;

    typedef struct packed {
        logic              wr;
        logic [IDX_W-1:0]  wr_index;
        logic [WORD_W-1:0] wr_data;
        logic [IDX_W-1:0]  rd_index;
    } mem_s;

endpackage : fp_dispatch_pkg

// ---- au_model.sv ----
// behavioural arithmetic unit on the far side of the dispatcher
`timescale 1ns/10ps
module au_model
    import fp_dispatch_pkg::*;
(
    // clock
    input  wire logic       clk_i,
    // request from the dispatcher
    input  wire au_req_s    req_i,
    // answer to the dispatcher
    output au_resp_s        resp_o,
    // bench controls
    input  wire logic [3:0] delay_i,
    input  wire logic       fail_i,
    // bench observation
    output au_req_s         seen_o,
    output int              n_req_o
);
    int                cnt;
    logic [OPND_W-1:0] r;
    au_resp_s          nx;

    initial begin
        cnt = -1;
        resp_o = '0;
        seen_o = '0;
        n_req_o = 0;
    end

    // answer lines other than done show their inverse outside the one-cycle answer; done stays low
    always @(posedge clk_i) begin
        nx = ~resp_o;
        nx.done = 1'b0;
        if (req_i.req) begin
            seen_o <= req_i;
            n_req_o <= n_req_o + 1;
            cnt <= int'(delay_i);
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end else if (cnt == 0) begin
            case (seen_o.op.kind)
                KIND_ADD: r = seen_o.opa + seen_o.opb;
                KIND_SUB: r = seen_o.opa - seen_o.opb;
                KIND_MUL: r = seen_o.opa * seen_o.opb;
                KIND_DIV: r = seen_o.opa ^ seen_o.opb;
                default:  r = ~seen_o.opb;
            endcase
            cnt <= -1;
            nx = {1'b1, r, seen_o.opb[4:0], seen_o.opa[1:0] ^ seen_o.opb[1:0], ~fail_i};
        end
        resp_o <= nx;
    end
endmodule : au_model

// ---- fp_operate_dispatch_tb_top.sv ----
// self-checking bench for the operate dispatcher
`timescale 1ns/10ps
module fp_operate_dispatch_tb_top;
    import fp_dispatch_pkg::*;
    logic        clk;
    logic        arst_n;
    logic        en;
    issue_s      iss;
    mem_s        mem;
    logic        busy;
    logic [31:0] rdd;
    au_req_s     au_req;
    au_resp_s    au_rsp;
    status_s     st;
    logic [3:0]  dly;
    logic        fail;
    au_req_s     seen;
    int          nreq;
    logic [31:0] f [32];
    int          errors;
    int          n_tests;

    fp_operate_dispatch u_fp_operate_dispatch (.clk_i(clk), .arst_n_i(arst_n), .en_i(en),
        .issue_i(iss), .busy_o(busy), .mem_i(mem), .mem_rd_data_o(rdd), .au_o(au_req),
        .au_i(au_rsp), .status_o(st));
    au_model u_au_model (.clk_i(clk), .req_i(au_req), .resp_o(au_rsp), .delay_i(dly),
        .fail_i(fail), .seen_o(seen), .n_req_o(nreq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string m, input logic [95:0] got, input logic [95:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic chk_st(input status_s got, input status_s exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: status got %h exp %h", $time, got, exp);
        end
    endtask : chk_st

    function automatic logic [95:0] opv(input logic [1:0] p, input logic [4:0] i);
        if (p == PREC_SGL) return {64'h0, f[i]};
        if (p == PREC_DBL) return {32'h0, f[i & 5'h1e], f[i | 5'h01]};
        return {f[i & 5'h1c], f[(i & 5'h1c) + 5'h01], f[(i & 5'h1c) + 5'h02]};
    endfunction : opv

    task automatic wb(input logic [1:0] p, input logic [4:0] i, input logic [95:0] r);
        if (p == PREC_SGL) begin
            f[i] = r[31:0];
        end else if (p == PREC_DBL) begin
            f[i & 5'h1e] = r[63:32];
            f[i | 5'h01] = r[31:0];
        end else begin
            f[i & 5'h1c] = r[95:64];
            f[(i & 5'h1c) + 5'h01] = r[63:32];
            f[(i & 5'h1c) + 5'h02] = r[31:0];
        end
    endtask : wb

    task automatic mem_wr(input logic [4:0] i, input logic [31:0] d);
        @(posedge clk);
        mem <= '{1'b1, i, d, 5'h00};
        @(posedge clk);
        mem.wr <= 1'b0;
        f[i] = d;
    endtask : mem_wr

    task automatic rd_all();
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            mem.rd_index <= 5'(i);
            repeat (2) @(posedge clk);
            chk("register word", {64'h0, rdd}, {64'h0, f[i]});
        end
    endtask : rd_all

    task automatic do_op(input logic [3:0] k, input logic [1:0] sp, input logic [1:0] dp,
                         input logic [4:0] a, input logic [4:0] b, input logic [4:0] d,
                         output status_s s);
        int n;
        @(posedge clk);
        iss <= {1'b1, k, sp, dp, a, b, d};
        @(posedge clk);
        iss.valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (n == 1) chk("busy", {95'h0, busy}, 96'h1);
        end while (st.done !== 1'b1 && n < 60);
        s = st;
        chk("idle", {95'h0, busy}, 96'h0);
        if (n >= 60) chk("completion", 96'h0, 96'h1);
    endtask : do_op

    task automatic run(input logic [3:0] k, input logic [1:0] sp, input logic [1:0] dp);
        logic [4:0]  a;
        logic [4:0]  b;
        logic [4:0]  d;
        logic [95:0] oa;
        logic [95:0] ob;
        logic [95:0] r;
        status_s     s;
        status_s     e;
        int          n0;
        a = 5'($urandom);
        b = 5'($urandom);
        d = 5'($urandom);
        oa = opv(sp, a);
        ob = opv(sp, b);
        n0 = nreq;
        dly <= 4'($urandom);
        do_op(k, sp, dp, a, b, d, s);
        e = '0;
        e.done = 1'b1;
        e.fcc = FCC_EQ;
        if (sp == 2'h3) begin
            e.illegal = 1'b1;
            chk("request count", 96'(nreq), 96'(n0));
        end else if (k <= KIND_ABS) begin
            e.c = 1'b1;
            r = {64'h0, f[b]};
            if (k == KIND_NEG) r[31:0] = f[b] ^ SIGN_MASK;
            if (k == KIND_ABS) r[31:0] = f[b] & MAG_MASK;
            wb(PREC_SGL, d, r);
            chk("request count", 96'(nreq), 96'(n0));
        end else begin
            chk("unit kind", 96'(seen.op.kind), 96'(k));
            chk("second operand", seen.opb, ob);
            if (k >= KIND_ADD) chk("first operand", seen.opa, oa);
            case (k)
                KIND_ADD: r = oa + ob;
                KIND_SUB: r = oa - ob;
                KIND_MUL: r = oa * ob;
                KIND_DIV: r = oa ^ ob;
                default:  r = ~ob;
            endcase
            e.c = ~fail;
            e.texc = ob[4:0];
            e.fcc = oa[1:0] ^ ob[1:0];
            if (k >= KIND_CMP) begin
                e.fcc_valid = 1'b1;
                e.fcc = oa[1:0] ^ ob[1:0];
            end else if (!fail) begin
                wb(dp, d, r);
            end
        end
        chk_st(s, e);
        rd_all();
        $display("test kind %0d prec %0d to %0d done", k, sp, dp);
    endtask : run

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    initial begin
        #300000;
        errors++;
        $display("wrong value at %0t: run did not finish", $time);
        print_verdict();
    end

    initial begin
        arst_n = 1'b0;
        en = 1'b1;
        iss = '0;
        mem = '0;
        dly = '0;
        fail = 1'b0;
        errors = 0;
        n_tests = 0;
        void'($urandom(94258));
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 32; i++) mem_wr(5'(i), $urandom);
        rd_all();
        $display("test register file done");
        // frozen enable drops a memory write
        @(posedge clk);
        en <= 1'b0;
        mem <= '{1'b1, 5'h00, ~f[0], 5'h00};
        repeat (3) @(posedge clk);
        mem.wr <= 1'b0;
        @(posedge clk);
        en <= 1'b1;
        rd_all();
        $display("test clock enable done");
        for (int k = 0; k <= 10; k++) begin
            for (int p = 0; p < 3; p++) begin
                if (k <= 2 && p > 0) continue;
                run(4'(k), 2'(p), (k == 3) ? 2'((p + 2) % 3) : 2'(p));
            end
        end
        fail <= 1'b1;
        run(KIND_ADD, PREC_SGL, PREC_SGL);
        fail <= 1'b0;
        run(KIND_MUL, 2'h3, 2'h3);
        print_verdict();
    end
endmodule : fp_operate_dispatch_tb_top
